// [inc/relay_timer_defines.svh]
/*
 * Timing counts, input positions and reset values of the relay delay timer.
 * Assumes it is included by bare name wherever the counts are needed.
 */
`ifndef RELAY_TIMER_DEFINES_SVH
`define RELAY_TIMER_DEFINES_SVH

// ----------------------------------------------------------------------
// Timing, in oscillator periods, and counter widths in bits
// ----------------------------------------------------------------------
`define DEBOUNCE_INTERVAL_PERIODS 6
`define HOLD_INTERVAL_PERIODS 73728
`define DEBOUNCE_CNT_W 3
`define HOLD_CNT_W 17

// ----------------------------------------------------------------------
// Input vector bit positions
// ----------------------------------------------------------------------
`define IN_NUM 3
`define IN_TOGGLE 0
`define IN_ON 1
`define IN_OFF 2

// ----------------------------------------------------------------------
// Reset values and synchroniser depth
// ----------------------------------------------------------------------
`define SYNC_STAGES 2
`define RELAY_RESET_VALUE 1'b0
`define INPUTS_RESET_VALUE 3'h0

`endif

// [inc/relay_timer_pkg.sv]
/*
 * Types and shared decode functions of the relay delay timer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package relay_timer_pkg;

    // ------------------------------------------------------------------
    // Relay state
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        RELAY_IDLE = 2'b01,
        RELAY_HOLD = 2'b10
    } relay_state_t;

    // ------------------------------------------------------------------
    // Edge decode
    // ------------------------------------------------------------------
    function automatic logic rise_of(input logic cur, input logic prev);
        rise_of = cur & ~prev;
    endfunction : rise_of

endpackage : relay_timer_pkg

// [rtl/input_debounce.sv]
/*
 * Shared debounce stage: one filter for the whole input vector.
 * Assumes inputs are already synchronised to mclk and tick is a one-cycle
 * pulse once per oscillator period.
 */
`timescale 1ns/1ps
`include "relay_timer_defines.svh"

module input_debounce #(
    parameter int WIDTH = `IN_NUM,
    parameter int PERIODS = `DEBOUNCE_INTERVAL_PERIODS,
    parameter int CNT_W = `DEBOUNCE_CNT_W
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Sampling
    input wire logic tick,
    input wire logic [WIDTH-1:0] raw,
    // Qualified levels
    output logic [WIDTH-1:0] stable
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] last_q;
    logic [WIDTH-1:0] last_d;
    logic [WIDTH-1:0] stable_q;
    logic [WIDTH-1:0] stable_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;

    localparam logic [CNT_W-1:0] LAST_CNT = CNT_W'(PERIODS - 1);

    // ------------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------------
    always_comb begin
        last_d = last_q;
        stable_d = stable_q;
        cnt_d = cnt_q;
        if (tick) begin
            last_d = raw;
            if (raw != last_q) begin
                cnt_d = '0; // [RULE13]
            end else if (cnt_q < LAST_CNT) begin
                cnt_d = cnt_q + CNT_W'(1);
            end else begin
                stable_d = last_q; // [RULE1]
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            last_q <= '0;
            stable_q <= '0;
            cnt_q <= '0;
        end else begin
            last_q <= last_d;
            stable_q <= stable_d;
            cnt_q <= cnt_d;
        end
    end

    assign stable = stable_q;

endmodule : input_debounce

// [rtl/relay_delay_timer.sv]
/*
 * Long-term relay delay timer: three push-button inputs start or stop a
 * timed relay period counted in oscillator periods.
 * Assumes the buttons and the oscillator are asynchronous pins, mclk is
 * much faster than the oscillator, and rst_n comes from power-on reset.
 */
// Notes on behaviour
// [RULE1] Inputs qualify after six stable oscillator periods
// [RULE2] Relay drops after 73728 oscillator periods
// [RULE3] Power-up reset leaves relay off
// [RULE4] Trigger while active never restarts count
// [RULE5] Manual stop ends period immediately
// [RULE6] First toggle press turns relay on
// [RULE7] Further toggle presses invert relay
// [RULE8] Untouched toggle period ends at expiry
// [RULE9] Switch-on press starts relay and count
// [RULE10] Switch-off press ends period
// [RULE11] Switch-on period ends at expiry
// [RULE12] All inputs share one debounce stage
// [RULE13] Both press and release are debounced
// [RULE14] Held switch-on never retriggers
// [RULE15] Outside switch avoids on plus off
// [RULE16] Switch-off wins over switch-on
// [RULE17] Counter clears whenever relay is off
`timescale 1ns/1ps
`include "relay_timer_defines.svh"

module relay_delay_timer #(
    parameter int DEBOUNCE_PERIODS = `DEBOUNCE_INTERVAL_PERIODS,
    parameter int HOLD_PERIODS = `HOLD_INTERVAL_PERIODS,
    parameter int HOLD_W = `HOLD_CNT_W
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Oscillator pin
    input wire logic osc_in,
    // Push-button pins
    input wire logic toggle_button,
    input wire logic switch_on,
    input wire logic switch_off,
    // Relay driver
    output logic relay_on,
    // Status
    output logic hold_active,
    output logic hold_expired,
    output logic [HOLD_W-1:0] hold_count
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    localparam int N = `IN_NUM;
    localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_PERIODS - 1);

    logic [N-1:0] pins;
    logic [N-1:0] sync1_q;
    logic [N-1:0] sync2_q;
    logic [N-1:0] deb;
    logic [N-1:0] deb_prev_q;
    logic [N-1:0] deb_prev_d;

    logic osc_s1_q;
    logic osc_s2_q;
    logic osc_prev_q;
    logic osc_tick;

    logic toggle_press;
    logic on_press;
    logic off_level;
    logic expire;

    relay_timer_pkg::relay_state_t state_q;
    relay_timer_pkg::relay_state_t state_d;
    logic [HOLD_W-1:0] cnt_q;
    logic [HOLD_W-1:0] cnt_d;
    logic relay_q;
    logic relay_d;
    logic expired_q;
    logic expired_d;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    assign pins[`IN_TOGGLE] = toggle_button;
    assign pins[`IN_ON] = switch_on;
    assign pins[`IN_OFF] = switch_off;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_sync
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    sync1_q[g] <= 1'b0;
                    sync2_q[g] <= 1'b0;
                end else begin
                    sync1_q[g] <= pins[g];
                    sync2_q[g] <= sync1_q[g];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Oscillator tick
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_prev_q <= 1'b0;
        end else begin
            osc_s1_q <= osc_in;
            osc_s2_q <= osc_s1_q;
            osc_prev_q <= osc_s2_q;
        end
    end

    assign osc_tick = relay_timer_pkg::rise_of(osc_s2_q, osc_prev_q);

    // ------------------------------------------------------------------
    // Shared debounce stage
    // ------------------------------------------------------------------
    input_debounce #(
        .WIDTH(N),
        .PERIODS(DEBOUNCE_PERIODS),
        .CNT_W(`DEBOUNCE_CNT_W)
    ) u_debounce ( // [RULE12]
        .mclk(mclk),
        .rst_n(rst_n),
        .tick(osc_tick),
        .raw(sync2_q),
        .stable(deb)
    );

    // ------------------------------------------------------------------
    // Press decode
    // ------------------------------------------------------------------
    always_comb begin
        deb_prev_d = deb;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            deb_prev_q <= `INPUTS_RESET_VALUE;
        end else begin
            deb_prev_q <= deb_prev_d;
        end
    end

    // Toggle and switch-on trigger on the debounced rising edge only; switch-off acts on its held level
    assign toggle_press = relay_timer_pkg::rise_of(deb[`IN_TOGGLE],
                                                   deb_prev_q[`IN_TOGGLE]);
    assign on_press = relay_timer_pkg::rise_of(deb[`IN_ON], deb_prev_q[`IN_ON]); // [RULE14]
    assign off_level = deb[`IN_OFF];
    assign expire = osc_tick && (cnt_q == HOLD_LAST);

    // ------------------------------------------------------------------
    // Relay state machine
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        relay_d = relay_q;
        expired_d = 1'b0;
        case (state_q)
            relay_timer_pkg::RELAY_IDLE: begin
                relay_d = 1'b0;
                if (off_level) begin
                    state_d = relay_timer_pkg::RELAY_IDLE; // [RULE16]
                end else if (toggle_press || on_press) begin
                    state_d = relay_timer_pkg::RELAY_HOLD; // [RULE6] [RULE9]
                    relay_d = 1'b1;
                end
            end
            relay_timer_pkg::RELAY_HOLD: begin
                if (off_level) begin
                    state_d = relay_timer_pkg::RELAY_IDLE; // [RULE5] [RULE10]
                    relay_d = 1'b0;
                end else if (toggle_press) begin
                    state_d = relay_timer_pkg::RELAY_IDLE; // [RULE7]
                    relay_d = 1'b0;
                end else if (expire) begin
                    state_d = relay_timer_pkg::RELAY_IDLE; // [RULE2] [RULE8] [RULE11]
                    relay_d = 1'b0;
                    expired_d = 1'b1;
                end else begin
                    // A switch-on press here is ignored
                    state_d = relay_timer_pkg::RELAY_HOLD; // [RULE4]
                    relay_d = 1'b1;
                end
            end
            default: begin
                state_d = relay_timer_pkg::RELAY_IDLE;
                relay_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= relay_timer_pkg::RELAY_IDLE; // [RULE3]
            relay_q <= `RELAY_RESET_VALUE; // [RULE3]
            expired_q <= 1'b0;
        end else begin
            state_q <= state_d;
            relay_q <= relay_d;
            expired_q <= expired_d;
        end
    end

    // ------------------------------------------------------------------
    // Hold counter
    // ------------------------------------------------------------------
    always_comb begin
        cnt_d = cnt_q;
        if (!relay_d) begin
            cnt_d = '0; // [RULE17]
        end else if (state_q == relay_timer_pkg::RELAY_IDLE) begin
            cnt_d = '0;
        end else if (osc_tick) begin
            cnt_d = cnt_q + HOLD_W'(1); // [RULE2]
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign relay_on = relay_q;
    assign hold_active = (state_q == relay_timer_pkg::RELAY_HOLD);
    assign hold_expired = expired_q;
    assign hold_count = cnt_q;

endmodule : relay_delay_timer

// [sim/button_panel.sv]
/*
 * Far side of the timer: push-button contacts, RC oscillator and relay coil.
 * Assumes the bench sets the contact vector {toggle, on, off} off the mclk edge.
 */
`timescale 1ns/1ps

module button_panel #(
    parameter int OSC_HALF_NS = 32
) (
    // Contacts commanded by the bench
    input wire logic [2:0] press,
    // Pins towards the timer
    output logic osc_in,
    output logic toggle_button,
    output logic switch_on,
    output logic switch_off,
    // Relay coil
    input wire logic relay_on,
    output logic coil_energised
);
    // ----------------------------------------------------------------
    // Free-running oscillator, unrelated in phase to mclk
    // ----------------------------------------------------------------
    initial begin
        osc_in = 1'b0;
        #5;
        forever #OSC_HALF_NS osc_in = ~osc_in;
    end

    // Closed contacts pull to battery, open ones to the pull-down level
    // Rocker contacts: on and off closed together only when commanded
    assign toggle_button = press[2];
    assign switch_on = press[1];
    assign switch_off = press[0];
    assign coil_energised = relay_on;
endmodule : button_panel

// [sim/relay_delay_timer_properties.sv]
/*
 * Port-level properties of the relay delay timer.
 * Assumes a bind onto relay_delay_timer; pins change away from mclk edges.
 */
`timescale 1ns/1ps

module relay_timer_checker #(
    parameter int HOLD_PERIODS = 73728,
    parameter int HOLD_W = 17
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Pins
    input wire logic osc_in,
    input wire logic toggle_button,
    input wire logic switch_on,
    input wire logic switch_off,
    // Outputs
    input wire logic relay_on,
    input wire logic hold_active,
    input wire logic hold_expired,
    input wire logic [HOLD_W-1:0] hold_count
);
    // ----------------------------------------------------------------
    // Oscillator periods since the last change of any input pin
    // ----------------------------------------------------------------
    logic [2:0] pins_q;
    logic osc_q;
    logic [3:0] ticks_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pins_q <= 3'h0;
            osc_q <= 1'b0;
            ticks_q <= 4'h0;
        end else begin
            pins_q <= {toggle_button, switch_on, switch_off};
            osc_q <= osc_in;
            if ({toggle_button, switch_on, switch_off} != pins_q) ticks_q <= 4'h0;
            else if (osc_in && !osc_q && ticks_q != 4'hf) ticks_q <= ticks_q + 4'h1;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_reset_clear;
        $rose(rst_n) |-> !relay_on && !hold_active && !hold_expired && hold_count == '0;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear after reset");
    property p_expiry_count;
        hold_expired |-> $past(hold_count) == HOLD_PERIODS - 1 && !relay_on;
    endproperty
    a_expiry_count: assert property (p_expiry_count) else $error("expiry at wrong count");
    property p_idle_clear;
        !relay_on |-> hold_count == '0;
    endproperty
    a_idle_clear: assert property (p_idle_clear) else $error("count not clear while idle");
    property p_no_restart;
        $past(relay_on) && relay_on |-> hold_count - $past(hold_count) <= 1;
    endproperty
    a_no_restart: assert property (p_no_restart) else $error("hold count restarted");
    property p_rise_debounced;
        $rose(relay_on) |-> ticks_q >= 4'h6;
    endproperty
    a_rise_debounced: assert property (p_rise_debounced) else $error("rise before debounce");
    property p_fall_debounced;
        $fell(relay_on) && !hold_expired |-> ticks_q >= 4'h6;
    endproperty
    a_fall_debounced: assert property (p_fall_debounced) else $error("stop before debounce");
    property p_off_priority;
        $rose(relay_on) |-> !switch_off;
    endproperty
    a_off_priority: assert property (p_off_priority) else $error("relay on with off held");
    property p_held_on;
        hold_expired && switch_on |=> !relay_on [*8];
    endproperty
    a_held_on: assert property (p_held_on) else $error("held switch-on retriggered");
    property p_on_stands;
        $rose(relay_on) |=> relay_on [*8] ##0 hold_active;
    endproperty
    a_on_stands: assert property (p_on_stands) else $error("relay did not stand");
endmodule : relay_timer_checker

bind relay_delay_timer relay_timer_checker #(.HOLD_PERIODS(HOLD_PERIODS), .HOLD_W(HOLD_W)) u_chk (
    .mclk(mclk), .rst_n(rst_n), .osc_in(osc_in), .toggle_button(toggle_button),
    .switch_on(switch_on), .switch_off(switch_off), .relay_on(relay_on),
    .hold_active(hold_active), .hold_expired(hold_expired), .hold_count(hold_count));

// [sim/relay_delay_timer_tb.sv]
/*
 * Self-checking bench: table of contact steps against an integer model.
 * Assumes the oscillator period is 8 mclk and the hold is 30 periods.
 */
`timescale 1ns/1ps
`include "relay_timer_defines.svh"

module relay_delay_timer_tb;
    localparam int HOLD = 30;
    localparam int NSTEP = 31;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] press = 3'h0;
    logic osc_in, toggle_button, switch_on, switch_off, relay_on, hold_active, hold_expired;
    logic [`HOLD_CNT_W-1:0] hold_count;
    int err_total = 0;
    int cmp_count = 0;
    int pulses = 0;
    // Steps: bit 3 glitch first, then {toggle, on, off}
    logic [3:0] steps [NSTEP] = '{4'h0, 4'h4, 4'h0, 4'h4, 4'h0, 4'h4, 4'h0, 4'h0, 4'h0,
        4'h2, 4'h0, 4'h2, 4'h0, 4'h2, 4'h0, 4'h1, 4'h0, 4'h2, 4'h2, 4'h2, 4'h2, 4'h0,
        4'h3, 4'h0, 4'h8, 4'h4, 4'hc, 4'h1, 4'h0, 4'h5, 4'h0};

    always #4 mclk = ~mclk;
    always @(posedge mclk) if (hold_expired === 1'b1) pulses <= pulses + 1;

    button_panel u_panel (.press(press), .osc_in(osc_in), .toggle_button(toggle_button),
        .switch_on(switch_on), .switch_off(switch_off), .relay_on(relay_on),
        .coil_energised());
    relay_delay_timer #(.HOLD_PERIODS(HOLD)) u_dut (.mclk(mclk), .rst_n(rst_n),
        .osc_in(osc_in), .toggle_button(toggle_button), .switch_on(switch_on),
        .switch_off(switch_off), .relay_on(relay_on), .hold_active(hold_active),
        .hold_expired(hold_expired), .hold_count(hold_count));

    task automatic chk(input string nm, input logic [16:0] seen, input logic [16:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk

    task automatic wait_ticks(input int n);
        repeat (n * 8) @(negedge mclk);
    endtask : wait_ticks

    task automatic final_report();
        if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        int eo, age, ep, len, r;
        logic [2:0] pv, v, rise;
        eo = 0;
        age = 0;
        ep = 0;
        pv = 3'h0;
        r = $urandom(32'hd382_5e01);
        repeat (12) @(negedge mclk);
        rst_n = 1'b1;
        @(negedge mclk);
        chk("relay after reset", {16'h0000, relay_on}, 17'h0_0000);
        for (int i = 0; i < NSTEP; i++) begin
            v = steps[i][2:0];
            len = 10;
            if (steps[i][3]) begin
                r = 1 + ($urandom % 4);
                press = v ^ 3'h4;
                wait_ticks(r);
                len = len + r;
            end
            press = v;
            wait_ticks(10);
            if (eo != 0) begin
                age = age + len;
                if (age >= HOLD) begin
                    eo = 0;
                    ep++;
                end
            end
            rise = v & ~pv;
            if (v[0]) eo = 0;
            else if (rise[2]) begin
                eo = (eo == 0);
                age = 3;
            end else if (rise[1] && eo == 0) begin
                eo = 1;
                age = 3;
            end
            pv = v;
            chk("relay_on", {16'h0000, relay_on}, 17'(eo));
            chk("hold_active", {16'h0000, hold_active}, 17'(eo));
            chk("expiry pulses", 17'(pulses), 17'(ep));
            if (eo == 0) chk("idle hold_count", hold_count, 17'h0_0000);
        end
        final_report();
    end
endmodule : relay_delay_timer_tb
